//--- verilog/sritc_cfg.svh
`ifndef SRITC_CFG_SVH
`define SRITC_CFG_SVH

// command codes taken from the first byte of a frame
`define SRITC_CMD_STATUS 8'h04
`define SRITC_CMD_FIFO_RD 8'h05
`define SRITC_CMD_I2C_WR 8'h07
`define SRITC_CMD_I2C_RD 8'h08

// byte limits of one remote access
`define SRITC_MAX_BYTES 6'h20
`define SRITC_LEN_HI_BITS 7:5

// status byte layout
`define SRITC_STATUS_BUSY_BIT 0

// tunnel limits
`define SRITC_MIN_SLOTS 4'h2
`define SRITC_MIN_SLOTS_NARROW 4'h3
`define SRITC_MAX_SLOTS 4'hc
`define SRITC_STD_MAX_BYTES 8'h10
`define SRITC_MIN_TUNNEL_BYTES 8'h06

// slot width codes
`define SRITC_WIDTH_16 2'h0
`define SRITC_WIDTH_20 2'h1
`define SRITC_WIDTH_24 2'h2
`define SRITC_WIDTH_32 2'h3

`endif

//--- verilog/sritc_pkg.sv
package sritc_pkg;

    typedef enum {F_IDLE, F_CMD, F_WR_NODE, F_WR_DATA, F_RD_NODE, F_RD_LEN,
        F_RD_DONE, F_FIFO, F_STATUS, F_IGNORE} sritc_frame_st_t;

    typedef enum {R_IDLE, R_SEND, R_WAIT} sritc_rem_st_t;

    typedef struct packed {
        logic [7:0] node;
        logic [7:0] data;
        logic isRead;
        logic last;
    } sritc_ctrl_frame_t;

    typedef struct packed {
        logic [7:0] data;
        logic err;
    } sritc_resp_frame_t;

    typedef struct packed {
        logic enable;
        logic firstNode;
        logic lastNode;
    } sritc_tunnel_cfg_t;

    typedef struct packed {
        logic [3:0] upCount;
        logic [3:0] downCount;
        logic [5:0] upOffset;
        logic [5:0] downOffset;
        logic [1:0] upWidth;
        logic [1:0] downWidth;
    } sritc_tunnel_slots_t;

endpackage

//--- verilog/sritc_ctrl.sv
`include "sritc_cfg.svh"

module sritc_ctrl
    import sritc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic spiClk,
    input wire logic addressPinOneN,
    input wire logic mosi,
    output logic miso,
    output logic misoOe,
    output logic spiEngineBusy,
    output logic remoteI2cErrorFlag,
    output logic badCommandFlag,
    output logic fifoUnderflowFlag,
    input wire logic [2:0] clearFlags,
    input wire logic superframeTick,
    output logic ctrlFrameValid,
    output sritc_ctrl_frame_t ctrlFrame,
    input wire logic respFrameValid,
    input wire sritc_resp_frame_t respFrame,
    input wire sritc_tunnel_cfg_t tunnelCfg,
    input wire sritc_tunnel_slots_t tunnelSlots,
    input wire logic slotStrobe,
    input wire logic [5:0] slotIndex,
    input wire logic [31:0] aPortSlot,
    input wire logic [31:0] bPortSlot,
    input wire logic [31:0] downPacketWord,
    input wire logic downPacketActive,
    input wire logic [31:0] upPacketWord,
    input wire logic upPacketActive,
    output logic [31:0] downSlotOut,
    output logic [31:0] upSlotOut,
    output logic downTunnelHit,
    output logic upTunnelHit,
    output logic upJumbo,
    output logic downJumbo,
    output logic tunnelCfgOk
);

    // all checks below run on the system clock
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // serial clock domain
    logic [2:0] bitCnt;
    logic [6:0] rxShift;
    logic [7:0] cmdByte;
    logic pastCmd;
    logic [7:0] rxByte;
    logic rxToggle;
    logic [7:0] misoShift;
    logic [7:0] txByte;
    logic [7:0] statusSnap;

    // select high clears the frame state, the serial clock may stop
    always_ff @(posedge spiClk or posedge addressPinOneN) begin
        if (addressPinOneN) begin
            bitCnt <= 3'h0;
            rxShift <= 7'h00;
            cmdByte <= 8'h00;
            pastCmd <= 1'b0;
        end else begin
            bitCnt <= bitCnt + 3'h1;
            rxShift <= {rxShift[5:0], mosi};
            if (bitCnt == 3'h7 && !pastCmd) begin
                cmdByte <= {rxShift, mosi};
                pastCmd <= 1'b1;
            end
        end
    end

    // rxByte holds for a whole byte time after the toggle
    always_ff @(posedge spiClk or posedge rst) begin
        if (rst) begin
            rxByte <= 8'h00;
            rxToggle <= 1'b0;
        end else if (bitCnt == 3'h7) begin
            rxByte <= {rxShift, mosi};
            rxToggle <= ~rxToggle;
        end
    end

    // txByte and statusSnap are set a byte time ahead of their use
    always_ff @(negedge spiClk or posedge addressPinOneN) begin
        if (addressPinOneN) begin
            misoShift <= 8'h00;
            miso <= 1'b0;
            misoOe <= 1'b0;
        end else begin
            misoOe <= 1'b1;
            if (bitCnt == 3'h0 && pastCmd) begin
                if (cmdByte == `SRITC_CMD_STATUS) begin
                    miso <= statusSnap[7];
                    misoShift <= {statusSnap[6:0], 1'b0};
                end else begin
                    miso <= txByte[7];
                    misoShift <= {txByte[6:0], 1'b0};
                end
            end else begin
                miso <= misoShift[7];
                misoShift <= {misoShift[6:0], 1'b0};
            end
        end
    end

    // crossing into clk
    logic [2:0] togSync;
    logic [2:0] selSync;
    logic togSeen;
    logic selLevel;
    logic byteEv;
    logic selChange;
    logic frameStart;
    logic frameEnd;

    always_ff @(posedge clk) begin
        if (rst) begin
            togSync <= 3'h0;
            selSync <= 3'h7;
            togSeen <= 1'b0;
            selLevel <= 1'b1;
        end else begin
            togSync <= {togSync[1:0], rxToggle};
            selSync <= {selSync[1:0], addressPinOneN};
            if (togSync[1] == togSync[2])
                togSeen <= togSync[2];
            if (frameStart || frameEnd)
                selLevel <= selSync[2];
        end
    end

    assign byteEv = (togSync[1] == togSync[2]) && (togSync[2] != togSeen);
    assign selChange = (selSync[1] == selSync[2]) && (selSync[2] != selLevel);
    assign frameStart = selChange && !selSync[2];
    // a last byte landing with the select edge is taken first
    assign frameEnd = selChange && selSync[2] && !byteEv;

    // command decode
    sritc_frame_st_t fst;
    sritc_rem_st_t remSt;
    logic [7:0] byteCnt;
    logic pending;
    logic [7:0] wrNode;
    logic [7:0] rdNode;
    logic [5:0] rdLen;
    logic [5:0] wrCount;
    logic [7:0] wrBuf [0:31];
    logic [7:0] fifoMem [0:31];
    logic [5:0] fifoCount;
    logic engDone;
    logic engErr;
    logic cmdEv;
    logic isI2cCmd;
    logic validCmd;
    logic acceptI2c;
    logic badEv;
    logic unfEv;
    logic launchWr;
    logic launchRd;
    logic cancel;
    logic [7:0] nextByteCnt;

    function automatic logic [7:0] fifoAt(input logic [7:0] i);
        if (i < {2'b00, fifoCount})
            return fifoMem[i[4:0]];
        return 8'h00;
    endfunction

    assign cmdEv = byteEv && fst == F_CMD;
    assign isI2cCmd = rxByte == `SRITC_CMD_I2C_WR
        || rxByte == `SRITC_CMD_I2C_RD;
    assign validCmd = isI2cCmd || rxByte == `SRITC_CMD_FIFO_RD
        || rxByte == `SRITC_CMD_STATUS;
    assign acceptI2c = cmdEv && isI2cCmd && !spiEngineBusy;
    assign badEv = (cmdEv && (!validCmd || (isI2cCmd && spiEngineBusy)))
        || (byteEv && fst == F_RD_LEN
        && rxByte[`SRITC_LEN_HI_BITS] != 3'h0);
    assign unfEv = byteEv && fst == F_FIFO
        && (8'(byteCnt - 8'h01) >= {2'b00, fifoCount});
    assign launchWr = frameEnd && pending && fst == F_WR_DATA
        && wrCount != 6'h00;
    assign launchRd = frameEnd && pending && fst == F_RD_DONE;
    assign cancel = frameEnd && pending && !launchWr && !launchRd;
    assign nextByteCnt = 8'(byteCnt + 8'h01);

    always_ff @(posedge clk) begin
        if (rst) begin
            fst <= F_IDLE;
            byteCnt <= 8'h00;
            pending <= 1'b0;
            wrNode <= 8'h00;
            rdNode <= 8'h00;
            rdLen <= 6'h00;
            wrCount <= 6'h00;
            txByte <= 8'h00;
            statusSnap <= 8'h00;
        end else if (frameStart) begin
            fst <= F_CMD;
            byteCnt <= 8'h00;
            pending <= 1'b0;
            wrCount <= 6'h00;
            txByte <= fifoAt(8'h00);
            statusSnap <= 8'h00;
            statusSnap[`SRITC_STATUS_BUSY_BIT] <= spiEngineBusy;
        end else if (frameEnd) begin
            fst <= F_IDLE;
            pending <= 1'b0;
        end else if (byteEv) begin
            if (byteCnt != 8'hff)
                byteCnt <= nextByteCnt;
            txByte <= fifoAt(nextByteCnt);
            case (fst)
                F_CMD: begin
                    if (!validCmd || (isI2cCmd && spiEngineBusy)) begin
                        fst <= F_IGNORE;
                    end else if (rxByte == `SRITC_CMD_I2C_WR) begin
                        fst <= F_WR_NODE;
                        pending <= 1'b1;
                    end else if (rxByte == `SRITC_CMD_I2C_RD) begin
                        fst <= F_RD_NODE;
                        pending <= 1'b1;
                    end else if (rxByte == `SRITC_CMD_FIFO_RD) begin
                        fst <= F_FIFO;
                    end else begin
                        fst <= F_STATUS;
                    end
                end
                F_WR_NODE: begin
                    wrNode <= rxByte;
                    fst <= F_WR_DATA;
                end
                F_WR_DATA: begin
                    // bytes past the limit are dropped
                    if (wrCount < `SRITC_MAX_BYTES) begin
                        wrBuf[wrCount[4:0]] <= rxByte;
                        wrCount <= wrCount + 6'h01;
                    end
                end
                F_RD_NODE: begin
                    rdNode <= rxByte;
                    fst <= F_RD_LEN;
                end
                F_RD_LEN: begin
                    if (rxByte[`SRITC_LEN_HI_BITS] != 3'h0) begin
                        fst <= F_IGNORE;
                    end else begin
                        rdLen <= {1'b0, rxByte[4:0]} + 6'h01;
                        fst <= F_RD_DONE;
                    end
                end
                default: fst <= fst;
            endcase
        end
    end

    // remote engine
    logic [5:0] remLen;
    logic [5:0] remIdx;
    logic remIsRead;
    logic [7:0] remNode;
    logic remLast;

    assign remLast = remIdx == 6'(remLen - 6'h01);

    // one control frame per superframe, paced by the response
    always_ff @(posedge clk) begin
        if (rst) begin
            remSt <= R_IDLE;
            remLen <= 6'h00;
            remIdx <= 6'h00;
            remIsRead <= 1'b0;
            remNode <= 8'h00;
            fifoCount <= 6'h00;
            ctrlFrameValid <= 1'b0;
            ctrlFrame <= '0;
            engDone <= 1'b0;
            engErr <= 1'b0;
        end else begin
            ctrlFrameValid <= 1'b0;
            engDone <= 1'b0;
            engErr <= 1'b0;
            case (remSt)
                R_IDLE: begin
                    remIdx <= 6'h00;
                    if (launchWr) begin
                        remSt <= R_SEND;
                        remIsRead <= 1'b0;
                        remLen <= wrCount;
                        remNode <= wrNode;
                    end else if (launchRd) begin
                        remSt <= R_SEND;
                        remIsRead <= 1'b1;
                        remLen <= rdLen;
                        remNode <= rdNode;
                        fifoCount <= 6'h00;
                    end
                end
                R_SEND: begin
                    if (superframeTick) begin
                        ctrlFrameValid <= 1'b1;
                        ctrlFrame.node <= remNode;
                        ctrlFrame.data <= remIsRead ? {2'b00, remIdx}
                            : wrBuf[remIdx[4:0]];
                        ctrlFrame.isRead <= remIsRead;
                        ctrlFrame.last <= remLast;
                        remSt <= R_WAIT;
                    end
                end
                R_WAIT: begin
                    if (respFrameValid) begin
                        if (respFrame.err) begin
                            engErr <= 1'b1;
                            engDone <= 1'b1;
                            remSt <= R_IDLE;
                        end else begin
                            if (remIsRead) begin
                                fifoMem[remIdx[4:0]] <= respFrame.data;
                                fifoCount <= fifoCount + 6'h01;
                            end
                            if (remLast) begin
                                engDone <= 1'b1;
                                remSt <= R_IDLE;
                            end else begin
                                remIdx <= remIdx + 6'h01;
                                remSt <= R_SEND;
                            end
                        end
                    end
                end
                default: remSt <= R_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst)
            spiEngineBusy <= 1'b0;
        else if (acceptI2c)
            spiEngineBusy <= 1'b1;
        else if (engDone || cancel)
            spiEngineBusy <= 1'b0;
    end

    // a new event outweighs a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            remoteI2cErrorFlag <= 1'b0;
            badCommandFlag <= 1'b0;
            fifoUnderflowFlag <= 1'b0;
        end else begin
            if (engErr)
                remoteI2cErrorFlag <= 1'b1;
            else if (clearFlags[0])
                remoteI2cErrorFlag <= 1'b0;
            if (badEv)
                badCommandFlag <= 1'b1;
            else if (clearFlags[1])
                badCommandFlag <= 1'b0;
            if (unfEv)
                fifoUnderflowFlag <= 1'b1;
            else if (clearFlags[2])
                fifoUnderflowFlag <= 1'b0;
        end
    end

    // data tunnel slots
    function automatic logic [7:0] tunnelBytes(input logic [3:0] cnt,
        input logic [1:0] code);
        logic [9:0] bits;
        bits = 10'h000;
        case (code)
            `SRITC_WIDTH_16: bits = {6'h00, cnt} << 4;
            `SRITC_WIDTH_20: bits = 10'({6'h00, cnt} * 10'h014);
            `SRITC_WIDTH_24: bits = 10'({6'h00, cnt} * 10'h018);
            default: bits = {6'h00, cnt} << 5;
        endcase
        return {1'b0, bits[9:3]};
    endfunction

    function automatic logic countOk(input logic [3:0] cnt,
        input logic [1:0] code);
        logic [3:0] least;
        least = (code == `SRITC_WIDTH_16 || code == `SRITC_WIDTH_20)
            ? `SRITC_MIN_SLOTS_NARROW : `SRITC_MIN_SLOTS;
        return cnt >= least && cnt <= `SRITC_MAX_SLOTS
            && tunnelBytes(cnt, code) >= `SRITC_MIN_TUNNEL_BYTES;
    endfunction

    function automatic logic inWindow(input logic [5:0] off,
        input logic [3:0] cnt);
        logic [6:0] top;
        top = {1'b0, off} + {3'b000, cnt};
        return cnt >= `SRITC_MIN_SLOTS && cnt <= `SRITC_MAX_SLOTS
            && slotIndex >= off && {1'b0, slotIndex} < top;
    endfunction

    logic downWin;
    logic upWin;
    assign downWin = tunnelCfg.enable
        && inWindow(tunnelSlots.downOffset, tunnelSlots.downCount);
    assign upWin = tunnelCfg.enable
        && inWindow(tunnelSlots.upOffset, tunnelSlots.upCount);

    always_ff @(posedge clk) begin
        if (rst) begin
            upJumbo <= 1'b0;
            downJumbo <= 1'b0;
            tunnelCfgOk <= 1'b0;
        end else begin
            upJumbo <= tunnelBytes(tunnelSlots.upCount, tunnelSlots.upWidth)
                > `SRITC_STD_MAX_BYTES;
            downJumbo <= tunnelBytes(tunnelSlots.downCount,
                tunnelSlots.downWidth) > `SRITC_STD_MAX_BYTES;
            tunnelCfgOk <= countOk(tunnelSlots.upCount, tunnelSlots.upWidth)
                && countOk(tunnelSlots.downCount, tunnelSlots.downWidth);
        end
    end

    // first and last are independent, so a lone node fills both
    always_ff @(posedge clk) begin
        if (rst) begin
            downSlotOut <= 32'h0000_0000;
            upSlotOut <= 32'h0000_0000;
            downTunnelHit <= 1'b0;
            upTunnelHit <= 1'b0;
        end else begin
            downTunnelHit <= slotStrobe && downWin;
            upTunnelHit <= slotStrobe && upWin;
            if (slotStrobe) begin
                downSlotOut <= aPortSlot;
                upSlotOut <= bPortSlot;
                if (downWin && tunnelCfg.firstNode)
                    downSlotOut <= downPacketActive ? downPacketWord
                        : 32'h0000_0000;
                if (upWin && tunnelCfg.lastNode)
                    upSlotOut <= upPacketActive ? upPacketWord
                        : 32'h0000_0000;
            end
        end
    end

    // checks

    property p_busy_set;
        acceptI2c |=> spiEngineBusy [*2];
    endproperty
    a_busy_set: assert property (p_busy_set)
        else $error("busy not held after accepted request");

    property p_busy_bad;
        cmdEv && isI2cCmd && spiEngineBusy |=> badCommandFlag
            && fst == F_IGNORE;
    endproperty
    a_busy_bad: assert property (p_busy_bad)
        else $error("request while busy not flagged");

    property p_invalid_cmd;
        cmdEv && !validCmd |=> badCommandFlag && !pending;
    endproperty
    a_invalid_cmd: assert property (p_invalid_cmd)
        else $error("invalid command not flagged or not ignored");

    property p_one_per_tick;
        ctrlFrameValid |-> $past(superframeTick) && !$past(ctrlFrameValid);
    endproperty
    a_one_per_tick: assert property (p_one_per_tick)
        else $error("control frame without superframe tick");

    property p_err_flag;
        remSt == R_WAIT && respFrameValid && respFrame.err
            |=> ##1 remoteI2cErrorFlag && !spiEngineBusy;
    endproperty
    a_err_flag: assert property (p_err_flag)
        else $error("remote failure not reported");

    property p_fifo_limit;
        fifoCount <= `SRITC_MAX_BYTES && wrCount <= `SRITC_MAX_BYTES;
    endproperty
    a_fifo_limit: assert property (p_fifo_limit)
        else $error("access longer than limit");

    property p_underflow;
        unfEv |=> fifoUnderflowFlag;
    endproperty
    a_underflow: assert property (p_underflow)
        else $error("fifo underflow not flagged");

    property p_pass_through;
        slotStrobe && !tunnelCfg.enable |=> downSlotOut == $past(aPortSlot)
            && upSlotOut == $past(bPortSlot) && !downTunnelHit;
    endproperty
    a_pass_through: assert property (p_pass_through)
        else $error("disabled node changed a slot");

    property p_status_quiet;
        byteEv && fst == F_STATUS |=> $stable(badCommandFlag)
            || $past(clearFlags[1]);
    endproperty
    a_status_quiet: assert property (p_status_quiet)
        else $error("status read raised a flag");

endmodule // sritc_ctrl

//--- tb/sritc_host.sv
module sritc_host (
    output logic spiClk,
    output logic addressPinOneN,
    output logic mosi,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] txB [8];
    logic [7:0] rxB [8];
    initial begin
        spiClk = 1'b0;
        addressPinOneN = 1'b1;
        mosi = 1'b0;
        foreach (txB[i]) txB[i] = 8'h00;
    end
    // mode 0, clock stands low outside frames
    task automatic xfer(input int n);
        addressPinOneN = 1'b0;
        #60;
        for (int i = 0; i < n * 8; i++) begin
            mosi = txB[i / 8][7 - i % 8];
            #6 spiClk = 1'b1;
            rxB[i / 8][7 - i % 8] = miso;
            #6 spiClk = 1'b0;
        end
        #60 addressPinOneN = 1'b1;
        // a released line must not keep echoing the last bit
        mosi = ~mosi;
        #60;
    endtask
endmodule // sritc_host

//--- tb/sritc_ctrl_tb.sv
module sritc_ctrl_tb
    import sritc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, spiClk, addressPinOneN, mosi, miso, misoOe;
    logic spiEngineBusy, remoteI2cErrorFlag, badCommandFlag;
    logic fifoUnderflowFlag, superframeTick, ctrlFrameValid;
    logic respFrameValid, slotStrobe, downPacketActive, upPacketActive;
    logic downTunnelHit, upTunnelHit, upJumbo, downJumbo, tunnelCfgOk;
    logic [2:0] clearFlags;
    logic [5:0] slotIndex;
    logic [31:0] aPortSlot, bPortSlot, downPacketWord, upPacketWord;
    logic [31:0] downSlotOut, upSlotOut;
    sritc_ctrl_frame_t ctrlFrame;
    sritc_resp_frame_t respFrame;
    sritc_tunnel_cfg_t tunnelCfg;
    sritc_tunnel_slots_t tunnelSlots;
    int nMismatch = 0;
    int nCompared = 0;
    int seed = 32'h8538;
    logic [7:0] wq [$];
    logic [7:0] fq [$];

    sritc_ctrl i_dut (.clk, .rst, .spiClk, .addressPinOneN, .mosi, .miso,
        .misoOe, .spiEngineBusy, .remoteI2cErrorFlag, .badCommandFlag,
        .fifoUnderflowFlag, .clearFlags, .superframeTick, .ctrlFrameValid,
        .ctrlFrame, .respFrameValid, .respFrame, .tunnelCfg, .tunnelSlots,
        .slotStrobe, .slotIndex, .aPortSlot, .bPortSlot, .downPacketWord,
        .downPacketActive, .upPacketWord, .upPacketActive, .downSlotOut,
        .upSlotOut, .downTunnelHit, .upTunnelHit, .upJumbo, .downJumbo,
        .tunnelCfgOk);
    sritc_host i_host (.spiClk, .addressPinOneN, .mosi, .miso);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic test_done;
        $display("compared %0d mismatched %0d", nCompared, nMismatch);
        if (nMismatch == 0 && nCompared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp) begin
            nMismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bound(inout int t);
        if (++t > 300) begin
            check(1'b0, 1'b1);
            test_done;
        end
        @(negedge clk);
    endtask

    task automatic frame(input int n, input logic [7:0] b0, b1, b2, b3);
        {i_host.txB[0], i_host.txB[1], i_host.txB[2], i_host.txB[3]} =
            {b0, b1, b2, b3};
        i_host.xfer(n);
        repeat (6) @(negedge clk);
    endtask

    task automatic clr(input logic [2:0] m);
        @(negedge clk) clearFlags = m;
        @(negedge clk) clearFlags = 3'h0;
    endtask

    // plays the remote node, its target address already programmed
    task automatic remote(input int n, input logic rd, input logic err,
            input logic [7:0] node);
        int t;
        logic [7:0] d;
        for (int k = 0; k < n; k++) begin
            @(negedge clk) superframeTick = 1'b1;
            @(negedge clk) superframeTick = 1'b0;
            t = 0;
            while (ctrlFrameValid !== 1'b1) bound(t);
            d = rd ? 8'(k) : wq.pop_front();
            check(ctrlFrame, {node, d, rd, k == n - 1});
            repeat (3) @(negedge clk) check(ctrlFrameValid, 1'b0);
            d = 8'($random(seed));
            respFrame = {d, err};
            respFrameValid = 1'b1;
            if (rd) fq.push_back(d);
            @(negedge clk) respFrameValid = 1'b0;
        end
    endtask

    initial begin
        int t;
        logic [7:0] node;
        logic dn, up;
        logic [31:0] eDn, eUp;
        {superframeTick, respFrameValid, slotStrobe, clearFlags} = 6'h00;
        {respFrame, tunnelCfg, tunnelSlots, slotIndex} = 42'h000_0000_0000;
        {aPortSlot, bPortSlot, downPacketWord, upPacketWord} = 128'h0;
        {downPacketActive, upPacketActive} = 2'h0;
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (6) @(negedge clk);
        check({spiEngineBusy, remoteI2cErrorFlag, badCommandFlag,
            fifoUnderflowFlag, miso, misoOe}, 6'h00);
        frame(1, 8'h03, 8'h00, 8'h00, 8'h00);
        check(badCommandFlag, 1'b1);
        clr(3'h2);
        node = 8'($random(seed));
        wq = {8'($random(seed)), 8'($random(seed))};
        frame(4, 8'h07, node, wq[0], wq[1]);
        check(spiEngineBusy, 1'b1);
        frame(2, 8'h04, 8'h00, 8'h00, 8'h00);
        check({i_host.rxB[1], badCommandFlag}, 9'h002);
        frame(3, 8'h08, node, 8'h00, 8'h00);
        check(badCommandFlag, 1'b1);
        clr(3'h2);
        remote(2, 1'b0, 1'b0, node);
        repeat (2) @(negedge clk);
        check(spiEngineBusy, 1'b0);
        frame(3, 8'h08, node, 8'h20, 8'h00);
        check({badCommandFlag, spiEngineBusy}, 2'h2);
        clr(3'h2);
        for (int r = 0; r < 2; r++) begin
            fq.delete();
            frame(3, 8'h08, node, 8'(r + 1), 8'h00);
            remote(r + 2, 1'b1, 1'b0, node);
            t = 0;
            while (spiEngineBusy !== 1'b0) bound(t);
        end
        frame(5, 8'h05, 8'h00, 8'h00, 8'h00);
        for (int j = 1; j < 5; j++)
            check(i_host.rxB[j], fq.size() ? fq.pop_front() : 8'h00);
        check(fifoUnderflowFlag, 1'b1);
        wq = {8'($random(seed))};
        frame(3, 8'h07, node, wq[0], 8'h00);
        remote(1, 1'b0, 1'b1, node);
        repeat (2) @(negedge clk);
        check({remoteI2cErrorFlag, spiEngineBusy}, 2'h2);
        clr(3'h7);
        check({remoteI2cErrorFlag, badCommandFlag, fifoUnderflowFlag}, 3'h0);
        // 3 and 5 slots of 32 bits: 12 bytes and 20 bytes
        tunnelSlots = '{4'h5, 4'h3, 6'h0a, 6'h04, 2'h3, 2'h3};
        for (int m = 0; m < 2; m++) begin
            tunnelCfg = m ? 3'h7 : 3'h0;
            for (int s = 0; s < 16; s++) begin
                @(negedge clk);
                {slotStrobe, slotIndex} = {1'b1, 6'(s)};
                aPortSlot = $random(seed);
                bPortSlot = $random(seed);
                downPacketWord = $random(seed);
                upPacketWord = $random(seed);
                {downPacketActive, upPacketActive} = 2'($random(seed));
                @(negedge clk) slotStrobe = 1'b0;
                dn = m && s >= 4 && s < 7;
                up = m && s >= 10 && s < 15;
                eDn = downPacketActive ? downPacketWord : 32'h0000_0000;
                eUp = upPacketActive ? upPacketWord : 32'h0000_0000;
                check({downTunnelHit, upTunnelHit}, {dn, up});
                check(downSlotOut, dn ? eDn : aPortSlot);
                check(upSlotOut, up ? eUp : bPortSlot);
            end
        end
        check({upJumbo, downJumbo, tunnelCfgOk}, 3'h5);
        test_done;
    end
endmodule // sritc_ctrl_tb
